// [isp_device_end.sv]
// Device end: I/O decode, DMA and interrupt pin drive, pin sharing
`timescale 1ns/1ps
`include "isp_params.svh"
module isp_device_end
   import isp_pkg::*;
#(
   parameter logic [`ISP_ADDR_W-1:0] BASE = `ISP_BASE_DEF
) (
   // Clock (14.31818 MHz reference derived clock)
   input wire logic mclk,
   // Bus
   isp_bus_if.device bus,
   // Audio DMA sources and their mapping
   input wire logic dma1Req,
   input wire logic dma2Req,
   input wire isp_chan_t dma1Chan,
   input wire isp_chan_t dma2Chan,
   input wire logic audioActive,
   output logic dma1Ack,
   output logic dma2Ack,
   // Interrupt sources and pin mapping, one-hot per source
   input wire logic [3:0] intSrc,
   input wire logic [3:0][`ISP_NUM_IRQ-1:0] intMap,
   input wire logic [3:0] srcActive,
   // Shared pins
   input wire logic mute_n,
   input wire logic hw_quieter_n,
   input wire logic hw_louder_n,
   output logic [4:0] volBtn,
   output logic [6:2] gpIn,
   // Configuration and expansion serial
   input wire logic autoconfig_enable,
   output logic autoconfigOn,
   input wire logic docked,
   input wire logic expClkDrv,
   input wire logic expDatDrv,
   input wire logic expDatOeReq,
   input wire logic exp_serial_dat_in,
   output logic exp_serial_clk_sync,
   output logic exp_serial_clk_sync_oe,
   output logic exp_serial_dat,
   output logic exp_serial_dat_oe,
   output logic expDatIn
);
   logic rst;
   logic [2:0] rdS_q, wrS_q, rdS_d, wrS_d;
   logic [`ISP_NUM_DMA-1:0] ak0_q, ak1_q, akP_q, ak0_d, ak1_d, akP_d;
   logic [7:0] ctrl_q, ctrl_d, gpo_q, gpo_d, data_q, data_d, rd_q, rd_d;
   logic oe_q, oe_d;
   logic hit, rdEdge, wrEdge;
   logic [3:0] regIdx;
   logic [`ISP_NUM_DMA-1:0] reqPin, reqOe, ackLow;
   isp_chan_t pinChan [`ISP_NUM_DMA];
   logic [`ISP_NUM_IRQ-1:0] irqLvl, irqAct, gpoSel;

   assign rst = bus.busReset;
   assign pinChan[0] = `ISP_CH_A;
   assign pinChan[1] = `ISP_CH_B;
   assign pinChan[2] = `ISP_CH_C;
   // Control: [0] channel two on, [1] channel one playback, [2] ack c as input,
   // [3] request c as input, [7:4] interrupt pins b..e as outputs
   assign gpoSel = {ctrl_q[7:4], 1'b0};

   // ==========================================
   // Synchronisers; the first stage feeds only the second
   always_comb begin
      rdS_d = {rdS_q[1:0], bus.io_read_strobe_n};
      wrS_d = {wrS_q[1:0], bus.io_write_strobe_n};
      ak0_d = bus.dmaAckN;
      ak1_d = ak0_q;
      akP_d = ak1_q;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rdS_q <= 3'h7;
         wrS_q <= 3'h7;
         ak0_q <= '1;
         ak1_q <= '1;
         akP_q <= '1;
      end else begin
         rdS_q <= rdS_d;
         wrS_q <= wrS_d;
         ak0_q <= ak0_d;
         ak1_q <= ak1_d;
         akP_q <= akP_d;
      end
   end

   // ==========================================
   // I/O decode; a strobe edge acts once per cycle
   assign hit = !bus.addrEnable && ((bus.addr & `ISP_WIN_MASK) == BASE);
   assign regIdx = bus.addr[3:0];
   // Edges use stages two and three only; stage one may still be settling
   assign rdEdge = rdS_q[2] && !rdS_q[1];
   assign wrEdge = wrS_q[2] && !wrS_q[1];
   assign ackLow = ~ak1_q & ~akP_q & {`ISP_NUM_DMA{bus.addrEnable}};

   always_comb begin
      ctrl_d = ctrl_q;
      gpo_d = gpo_q;
      data_d = data_q;
      rd_d = rd_q;
      // Drive data only while the read strobe is low and decoded
      oe_d = hit && !rdS_q[1];
      if (hit && wrEdge) begin
         if (regIdx == `ISP_REG_CTRL) begin
            ctrl_d = bus.hostData;
         end else if (regIdx == `ISP_REG_GPO) begin
            gpo_d = bus.hostData;
         end else if (regIdx == `ISP_REG_DATA) begin
            data_d = bus.hostData;
         end
      end
      if (hit && rdEdge) begin
         if (regIdx == `ISP_REG_CTRL) begin
            rd_d = ctrl_q;
         end else if (regIdx == `ISP_REG_STAT) begin
            rd_d = {docked, autoconfig_enable, 1'b0, intSrc, dma1Req};
         end else if (regIdx == `ISP_REG_GPO) begin
            rd_d = gpo_q;
         end else if (regIdx == `ISP_REG_GPI) begin
            rd_d = {1'b0, gpIn, 2'h0};
         end else if (regIdx == `ISP_REG_DATA) begin
            rd_d = data_q;
         end else begin
            rd_d = 8'h00;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_q <= `ISP_CTRL_RST;
         gpo_q <= 8'h00;
         data_q <= 8'h00;
         rd_q <= 8'h00;
         oe_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         gpo_q <= gpo_d;
         data_q <= data_d;
         rd_q <= rd_d;
         oe_q <= oe_d;
      end
   end

   // ==========================================
   // DMA pins: drive where a source's channel matches and it is active
   // Channel one may run either direction; the core owns that choice
   always_comb begin
      for (int i = 0; i < `ISP_NUM_DMA; i++) begin
         reqOe[i] = audioActive && (dma1Chan == pinChan[i] ||
            (ctrl_q[0] && dma2Chan == pinChan[i]));
         reqPin[i] = (dma1Chan == pinChan[i] && dma1Req) ||
            (ctrl_q[0] && dma2Chan == pinChan[i] && dma2Req);
      end
      if (ctrl_q[3]) begin
         reqOe[2] = 1'b0;
      end
   end
   assign bus.dmaReq = reqPin;
   assign bus.dmaReqOe = reqOe;
   assign dma1Ack = audioActive && (ackLow[0] && dma1Chan == pinChan[0] ||
      ackLow[1] && dma1Chan == pinChan[1] ||
      ackLow[2] && !ctrl_q[2] && dma1Chan == pinChan[2]);
   assign dma2Ack = audioActive && ctrl_q[0] && (ackLow[0] && dma2Chan == pinChan[0] ||
      ackLow[1] && dma2Chan == pinChan[1] ||
      ackLow[2] && !ctrl_q[2] && dma2Chan == pinChan[2]);

   // ==========================================
   // Interrupt pins: OR of mapped sources, driven if any is active
   always_comb begin
      irqLvl = '0;
      irqAct = '0;
      for (int s = 0; s < 4; s++) begin
         irqLvl = irqLvl | (intMap[s] & {`ISP_NUM_IRQ{intSrc[s]}});
         irqAct = irqAct | (intMap[s] & {`ISP_NUM_IRQ{srcActive[s]}});
      end
   end
   // A pin used as output drives its register bit instead
   assign bus.intOut = (irqLvl & ~gpoSel) | ({gpo_q[6:3], 1'b0} & gpoSel);
   assign bus.intOe = (irqAct & ~gpoSel) | gpoSel;
   assign bus.devData = rd_q;
   assign bus.devDataOe = oe_q;

   // ==========================================
   // Shared inputs; pull-ups are in the pad, levels pass through to gpIn and are inverted on volBtn
   assign volBtn = {3'h0, 2'h0} | {2'h0, ~mute_n, ~hw_quieter_n, ~hw_louder_n};
   assign gpIn = {hw_quieter_n, hw_louder_n, mute_n,
      ctrl_q[2] ? bus.dmaAckN[2] : 1'b1,
      ctrl_q[3] ? bus.dmaReq[2] : 1'b0};
   assign autoconfigOn = autoconfig_enable;

   // Expansion serial pins float while undocked
   assign exp_serial_clk_sync = expClkDrv;
   assign exp_serial_clk_sync_oe = docked;
   assign exp_serial_dat = expDatDrv;
   assign exp_serial_dat_oe = docked && expDatOeReq;
   assign expDatIn = exp_serial_dat_in;
endmodule

// [isp_params.svh]
// Constants for the expansion bus slave port and its host end
// ==========================================
// Behaviour
// - Address cycle when AEN low, DMA high
// - Separate low strobes, device drives data on reads
// - DMA request high, floatable; acknowledge low
// - Five interrupt outputs, drive or float
// - Interrupt pins b..e reusable as outputs 3..6
// - Ack c as input 3, request c as input 2
// - Volume buttons low active, or inputs 4,6,5
// - Autoconfig logic enabled by enable input high
// - Board routes interrupts to 9,5,7,10,11
// - Board routes DMA pairs to channels 0,1,3
// - Expansion serial pins float when undocked
// - Channel one: legacy/extended, record or playback
// - Channel two playback, mappable to 0,1,3
// - Software should prefer channel one on 1
// - Timing reference is 14.31818 MHz
// - Reset held while bus reset high
// - Request pin drives on channel match, activation
// - Interrupt pin drives when mapped source active
`ifndef ISP_PARAMS_SVH
`define ISP_PARAMS_SVH
`define ISP_ADDR_W 12
`define ISP_DATA_W 8
`define ISP_NUM_IRQ 5
`define ISP_NUM_DMA 3
`define ISP_REF_KHZ 14318
`define ISP_CLK_MHZ 20
`define ISP_CH_A 2'h0
`define ISP_CH_B 2'h1
`define ISP_CH_C 2'h3
`define ISP_CH_PREF 2'h1
`define ISP_SYNC_STAGES 2
`define ISP_BASE_DEF 12'h220
`define ISP_WIN_MASK 12'hFF0
`define ISP_REG_CTRL 4'h0
`define ISP_REG_STAT 4'h1
`define ISP_REG_GPO 4'h2
`define ISP_REG_GPI 4'h3
`define ISP_REG_DATA 4'h4
`define ISP_CTRL_RST 8'h00
`define ISP_FLOAT_RD 8'hFF
`endif

// [isp_pkg.sv]
// Types for the two ends of the expansion bus port: host end states, device end channel numbers
package isp_pkg;
   typedef enum {HS_IDLE, HS_SETUP, HS_STROBE, HS_HOLD} isp_host_st_t;
   typedef logic [1:0] isp_chan_t;
endpackage

// [isp_bus_if.sv]
// Interface joining the bus host and the device port
`timescale 1ns/1ps
`include "isp_params.svh"
interface isp_bus_if;
   logic [`ISP_ADDR_W-1:0] addr;
   logic addrEnable;
   logic io_read_strobe_n;
   logic io_write_strobe_n;
   logic [`ISP_DATA_W-1:0] hostData;
   logic [`ISP_DATA_W-1:0] devData;
   logic devDataOe;
   logic [`ISP_NUM_IRQ-1:0] intOut;
   logic [`ISP_NUM_IRQ-1:0] intOe;
   logic [`ISP_NUM_DMA-1:0] dmaReq;
   logic [`ISP_NUM_DMA-1:0] dmaReqOe;
   logic [`ISP_NUM_DMA-1:0] dmaAckN;
   logic busReset;
   modport device (input addr, addrEnable, io_read_strobe_n, io_write_strobe_n, hostData,
      dmaAckN, busReset, output devData, devDataOe, intOut, intOe, dmaReq, dmaReqOe);
   modport host (output addr, addrEnable, io_read_strobe_n, io_write_strobe_n, hostData,
      dmaAckN, busReset, input devData, devDataOe, intOut, intOe, dmaReq, dmaReqOe);
endinterface

// [isp_host_end.sv]
// Bus host end: runs single I/O cycles and answers DMA requests
`timescale 1ns/1ps
`include "isp_params.svh"
module isp_host_end
   import isp_pkg::*;
#(
   parameter int STROBE_CYC = 4
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Command port
   input wire logic cmdValid,
   input wire logic cmdWrite,
   input wire logic [`ISP_ADDR_W-1:0] cmdAddr,
   input wire logic [`ISP_DATA_W-1:0] cmdData,
   output logic cmdReady,
   output logic rspValid,
   output logic [`ISP_DATA_W-1:0] rspData,
   // DMA acknowledge enables, one per channel pair
   input wire logic [`ISP_NUM_DMA-1:0] dmaGrantEn,
   // Bus
   isp_bus_if.host bus
);
   isp_host_st_t st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic wr_q, wr_d;
   logic [`ISP_ADDR_W-1:0] addr_q, addr_d;
   logic [`ISP_DATA_W-1:0] dat_q, dat_d, rsp_q, rsp_d;
   logic rv_q, rv_d;
   logic [`ISP_NUM_DMA-1:0] ack_q, ack_d;
   logic [`ISP_NUM_DMA-1:0] reqSeen;

   // ==========================================
   // Request view: a floating request reads as idle
   assign reqSeen = bus.dmaReq & bus.dmaReqOe;

   // Address phase only when no DMA acknowledge is held
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      wr_d = wr_q;
      addr_d = addr_q;
      dat_d = dat_q;
      rsp_d = rsp_q;
      rv_d = 1'b0;
      ack_d = ack_q;
      case (st_q)
         HS_IDLE: begin
            if (cmdValid && ack_q == '0) begin
               wr_d = cmdWrite;
               addr_d = cmdAddr;
               dat_d = cmdData;
               st_d = HS_SETUP;
            end else begin
               // One acknowledge at a time, lowest channel first
               ack_d = '0;
               for (int i = 0; i < `ISP_NUM_DMA; i++) begin
                  if (reqSeen[i] && dmaGrantEn[i] && ack_d == '0) begin
                     ack_d[i] = 1'b1;
                  end
               end
            end
         end
         HS_SETUP: begin
            cnt_d = 4'(STROBE_CYC);
            st_d = HS_STROBE;
         end
         HS_STROBE: begin
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
               if (!wr_q) begin
                  rsp_d = bus.devDataOe ? bus.devData : `ISP_FLOAT_RD;
                  rv_d = 1'b1;
               end
               st_d = HS_HOLD;
            end
         end
         HS_HOLD: st_d = HS_IDLE;
         default: st_d = HS_IDLE;
      endcase
   end

   // State registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_q <= HS_IDLE;
         cnt_q <= 4'h0;
         wr_q <= 1'b0;
         addr_q <= '0;
         dat_q <= '0;
         rsp_q <= '0;
         rv_q <= 1'b0;
         ack_q <= '0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         wr_q <= wr_d;
         addr_q <= addr_d;
         dat_q <= dat_d;
         rsp_q <= rsp_d;
         rv_q <= rv_d;
         ack_q <= ack_d;
      end
   end

   // ==========================================
   // Bus drive; strobes only in the strobe state
   assign cmdReady = (st_q == HS_IDLE) && (ack_q == '0);
   assign rspValid = rv_q;
   assign rspData = rsp_q;
   assign bus.addr = addr_q;
   assign bus.addrEnable = (ack_q != '0);
   assign bus.io_read_strobe_n = !((st_q == HS_STROBE) && !wr_q);
   assign bus.io_write_strobe_n = !((st_q == HS_STROBE) && wr_q);
   assign bus.hostData = dat_q;
   assign bus.dmaAckN = ~ack_q;
   assign bus.busReset = rst;
endmodule

// [isp_bus_chk.sv]
// Concurrent checks on the bus between the host end and the device end
`timescale 1ns/1ps
`include "isp_params.svh"
module isp_bus_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic busReset,
   // Bus signals
   input wire logic [`ISP_ADDR_W-1:0] addr,
   input wire logic addrEnable,
   input wire logic io_read_strobe_n,
   input wire logic io_write_strobe_n,
   input wire logic devDataOe,
   input wire logic [`ISP_NUM_DMA-1:0] dmaReq,
   input wire logic [`ISP_NUM_DMA-1:0] dmaReqOe,
   input wire logic [`ISP_NUM_DMA-1:0] dmaAckN
);
   // ==========================================
   // Assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (busReset);
   logic inWin;
   // Window hit, only valid in an I/O cycle
   assign inWin = !addrEnable && ((addr & `ISP_WIN_MASK) == `ISP_BASE_DEF);
   rd_answer_a: assert property ($fell(io_read_strobe_n) && inWin |-> ##[1:3] devDataOe)
      else $error("no data drive for read in window");
   rd_outside_a: assert property ($fell(io_read_strobe_n) && !inWin |=> !devDataOe [*4])
      else $error("data driven for read outside window");
   wr_quiet_a: assert property (!io_write_strobe_n |-> !devDataOe)
      else $error("data driven during write");
   rd_release_a: assert property ($rose(io_read_strobe_n) |-> ##[1:3] !devDataOe)
      else $error("data drive held after read");
   // Slack of three edges covers the synchroniser and the output register
   oe_cause_a: assert property (devDataOe |-> !io_read_strobe_n || !$past(io_read_strobe_n)
      || !$past(io_read_strobe_n, 2) || !$past(io_read_strobe_n, 3))
      else $error("data drive without read strobe");
   strobe_excl_a: assert property (io_read_strobe_n || io_write_strobe_n)
      else $error("both strobes low");
   sync_delay_a: assert property ($fell(io_read_strobe_n) |-> !devDataOe)
      else $error("read answered before synchronising");
   ack_dma_a: assert property (dmaAckN != 3'h7 |-> addrEnable)
      else $error("acknowledge outside DMA cycle");
   ack_req_a: assert property ($fell(dmaAckN[0]) |-> $past(dmaReq[0] && dmaReqOe[0]))
      else $error("acknowledge without request");
   reset_quiet_a: assert property (disable iff (1'b0) busReset |=> !devDataOe)
      else $error("data driven in reset");
   // Main scenarios
   cover property ($fell(io_read_strobe_n) && inWin);
   cover property ($fell(io_write_strobe_n) && inWin);
   cover property ($fell(dmaAckN[0]));
endmodule

// [isa_slave_port_dma_pin_map_test.sv]
// Self-checking bench for both ends of the expansion bus
`timescale 1ns/1ps
`include "isp_params.svh"
module isa_slave_port_dma_pin_map_test
   import isp_pkg::*;
   ;
   logic mclk, rst, cmdValid, cmdWrite, cmdReady, rspValid;
   logic [11:0] cmdAddr;
   logic [7:0] cmdData, rspData, rd, v;
   logic [2:0] dmaGrantEn;
   logic dma1Req, dma2Req, audioActive, dma1Ack, dma2Ack, mute_n, hw_quieter_n, hw_louder_n;
   isp_chan_t dma1Chan, dma2Chan;
   isp_chan_t chans [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
   logic [3:0] intSrc, srcActive;
   logic [3:0][4:0] intMap;
   logic autoconfig_enable, autoconfigOn, docked, expClkDrv, expDatDrv, expDatOeReq, datIn;
   logic expClk, expClkOe, expDat, expDatOe, expDatIn;
   logic [4:0] volBtn;
   logic [6:2] gpIn;
   int bad_count = 0;
   int total_checks = 0;
   isp_bus_if bus ();
   isp_host_end #(.STROBE_CYC(4)) isp_host_end_i (.mclk(mclk), .rst(rst), .cmdValid(cmdValid),
      .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady),
      .rspValid(rspValid), .rspData(rspData), .dmaGrantEn(dmaGrantEn), .bus(bus));
   isp_device_end isp_device_end_i (.mclk(mclk), .bus(bus), .dma1Req(dma1Req),
      .dma2Req(dma2Req), .dma1Chan(dma1Chan), .dma2Chan(dma2Chan), .audioActive(audioActive),
      .dma1Ack(dma1Ack), .dma2Ack(dma2Ack), .intSrc(intSrc), .intMap(intMap),
      .srcActive(srcActive), .mute_n(mute_n), .hw_quieter_n(hw_quieter_n),
      .hw_louder_n(hw_louder_n), .volBtn(volBtn), .gpIn(gpIn),
      .autoconfig_enable(autoconfig_enable), .autoconfigOn(autoconfigOn), .docked(docked),
      .expClkDrv(expClkDrv), .expDatDrv(expDatDrv), .expDatOeReq(expDatOeReq),
      .exp_serial_dat_in(datIn), .exp_serial_clk_sync(expClk),
      .exp_serial_clk_sync_oe(expClkOe), .exp_serial_dat(expDat),
      .exp_serial_dat_oe(expDatOe), .expDatIn(expDatIn));
   isp_bus_chk isp_bus_chk_i (.mclk(mclk), .busReset(bus.busReset), .addr(bus.addr),
      .addrEnable(bus.addrEnable), .io_read_strobe_n(bus.io_read_strobe_n),
      .io_write_strobe_n(bus.io_write_strobe_n), .devDataOe(bus.devDataOe),
      .dmaReq(bus.dmaReq), .dmaReqOe(bus.dmaReqOe), .dmaAckN(bus.dmaAckN));
   // ==========================================
   // Clock, helpers and expectations
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      if (bad_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // One command through the host end; read data lands in rd
   task automatic io(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int n;
      @(negedge mclk);
      {cmdValid, cmdWrite, cmdAddr, cmdData} = {1'b1, wr, a, d};
      rd = 8'hXX;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (cmdReady !== 1'b1 && n < 50);
      if (cmdReady !== 1'b1) bad_count++;
      @(negedge mclk);
      cmdValid = 1'b0;
      n = 0;
      do begin
         @(posedge mclk);
         if (rspValid === 1'b1)
            rd = rspData;
         n++;
      end while (cmdReady !== 1'b1 && n < 50);
      // A command that never finishes counts against the run
      if (cmdReady !== 1'b1) bad_count++;
   endtask
   // Pins whose mapped sources are in the given set; board wires a..e in fixed order
   function automatic logic [4:0] pinMask(input logic [3:0] s);
      pinMask = 5'h00;
      for (int i = 0; i < 4; i++)
         if (s[i]) pinMask |= intMap[i];
   endfunction
   // Request pin a, b, c serves channel 0, 1, 3; anything else has no pin
   function automatic logic [2:0] reqPin(input isp_chan_t c);
      reqPin = (c == 2'h0) ? 3'h1 : (c == 2'h1) ? 3'h2 : (c == 2'h3) ? 3'h4 : 3'h0;
   endfunction
   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      complete_run();
   end
   // Main sequence
   initial begin
      v = 8'($urandom(32'hEE8B));
      {cmdValid, cmdWrite, cmdAddr, cmdData, dmaGrantEn, dma1Req, dma2Req, audioActive} = '0;
      {intSrc, srcActive, intMap, docked, expClkDrv, expDatDrv, expDatOeReq, datIn} = '0;
      {mute_n, hw_quieter_n, hw_louder_n, autoconfig_enable} = 4'hF;
      {dma1Chan, dma2Chan} = 4'h2;
      rst = 1'b1;
      repeat (20) @(negedge mclk);
      rst = 1'b0;
      io(1'b0, 12'h220, 8'h00);
      check(rd, 8'h00);
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 8'hFF : 8'($urandom);
         io(1'b1, 12'h224, v);
         io(1'b0, 12'h224, 8'h00);
         check(rd, v);
      end
      io(1'b1, 12'h22F, 8'h5A);
      io(1'b0, 12'h22F, 8'h00);
      check(rd, 8'h00);
      io(1'b0, 12'h320, 8'h00);
      check(rd, 8'hFF);
      // Channel matches pin a, so only the idle audio path keeps it floating
      for (int i = 0; i < 4; i++) begin
         @(negedge mclk);
         {docked, autoconfig_enable, intSrc, dma1Req, mute_n, hw_quieter_n, hw_louder_n} =
            10'($urandom);
         {expClkDrv, expDatDrv, expDatOeReq, datIn} = 4'($urandom);
         io(1'b0, 12'h221, 8'h00);
         check(rd, {docked, autoconfig_enable, 1'b0, intSrc, dma1Req});
         check(autoconfigOn, autoconfig_enable);
         check({expClkOe, expDatOe, expClk & expClkOe},
            docked ? {1'b1, expDatOeReq, expClkDrv} : 3'h0);
         check({expDat & expDatOe, expDatIn}, {docked & expDatOeReq & expDatDrv, datIn});
         check(bus.dmaReqOe, 3'h0);
         io(1'b0, 12'h223, 8'h00);
         check(rd, {1'b0, hw_quieter_n, hw_louder_n, mute_n, 4'h8});
         check(volBtn, {2'h0, ~mute_n, ~hw_quieter_n, ~hw_louder_n});
      end
      for (int i = 0; i < 6; i++) begin
         @(negedge mclk);
         for (int s = 0; s < 4; s++)
            intMap[s] = 5'(5'h01 << ($urandom % 5));
         srcActive = (i == 0) ? 4'h0 : 4'($urandom);
         intSrc = 4'($urandom) & srcActive;
         @(posedge mclk);
         check(bus.intOe, pinMask(srcActive));
         check(bus.intOut & bus.intOe, pinMask(intSrc));
      end
      v = 8'($urandom);
      io(1'b1, 12'h220, 8'hF0);
      io(1'b1, 12'h222, v);
      check(bus.intOe[4:1], 4'hF);
      check(bus.intOut[4:1], v[6:3]);
      @(negedge mclk);
      rst = 1'b1;
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      io(1'b0, 12'h220, 8'h00);
      check(rd, 8'h00);
      @(negedge mclk);
      {audioActive, dma1Req} = 2'h3;
      for (int p = 0; p < 4; p++) begin
         @(negedge mclk);
         dma1Chan = chans[p];
         @(posedge mclk);
         check(bus.dmaReqOe, reqPin(dma1Chan));
         check(bus.dmaReq & bus.dmaReqOe, reqPin(dma1Chan));
         @(negedge mclk);
         dmaGrantEn = reqPin(dma1Chan);
         for (int n = 0; n < 20 && dma1Ack !== 1'b1; n++) @(posedge mclk);
         check(dma1Ack, p < 3);
         @(negedge mclk);
         dmaGrantEn = 3'h0;
         repeat (8) @(negedge mclk);
      end
      io(1'b1, 12'h220, 8'h01);
      @(negedge mclk);
      {dma1Req, dma2Req, dma2Chan} = 4'h7;
      dmaGrantEn = 3'h4;
      @(posedge mclk);
      check(bus.dmaReqOe, 3'h4);
      for (int n = 0; n < 20 && dma2Ack !== 1'b1; n++) @(posedge mclk);
      check(dma2Ack, 1'b1);
      // Pin c pair turned into inputs: request floats, its level reads back as input two
      @(negedge mclk);
      dmaGrantEn = 3'h0;
      repeat (8) @(negedge mclk);
      io(1'b1, 12'h220, 8'h0D);
      io(1'b0, 12'h223, 8'h00);
      check(bus.dmaReqOe, 3'h0);
      check(dma2Ack, 1'b0);
      check(rd, {1'b0, hw_quieter_n, hw_louder_n, mute_n, 4'hC});
      complete_run();
   end
endmodule
